// ### rtl/wddc_dis_filter.sv
`timescale 1ns/1ps
// Dead-time filter on the disable level, both directions
module wddc_dis_filter
  import wddc_pkg::*;
#(
  parameter int unsigned FILT_CYC = DIS_FILT_CYC
) (
  input  wire logic      ref_clk_i,
  input  wire logic      srst_i,
  wddc_filt_if.filt      fif
);
  logic [CNT_W-1:0] cnt_ff;
  logic             dis_ff;

  // Count while raw level differs from settled one
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      cnt_ff <= '0;
      dis_ff <= 1'b0;
    end else if (fif.raw_dis == dis_ff) begin
      cnt_ff <= '0; // R15
    end else if (cnt_ff >= CNT_W'(FILT_CYC - 1)) begin
      cnt_ff <= '0;
      dis_ff <= fif.raw_dis; // R3 R5 R13
    end else begin
      cnt_ff <= cnt_ff + 1'b1;
    end
  end

  assign fif.dis_ok = dis_ff;
endmodule

// ### rtl/wddc_filt_if.sv
`timescale 1ns/1ps
// Filter request and its settled result
interface wddc_filt_if;
  logic raw_dis;
  logic dis_ok;
  modport filt (input raw_dis, output dis_ok);
  modport core (output raw_dis, input dis_ok);
endinterface

// ### rtl/wddc_pkg.sv
// Operation
// R1 - The trigger window is fixed at a typical 48 ms and the next trigger edge must arrive inside it.
// R2 - Holding the trigger input inside the disable level window is the disable request.
// R3 - The inactive state is entered only after the disable level has lasted the full filter time.
// R4 - Leaving the disable level reactivates the watchdog with an ignore window, then a new trigger window.
// R5 - The return from inactive to active uses the same filtered dead time as the entry.
// R6 - Disabled while waiting for a trigger, the output stays high for the whole disabled period.
// R7 - A missed trigger window drives the output low.
// R8 - Disabled during an output-low pulse, the output finishes the full low time and then goes high.
// R9 - After an output-low pulse an ignore window runs; disabled within it, the output stays high.
// R10 - With a low-current-load time shorter than the low time, disabling during a low pulse keeps the output low only while low-current-load lasts.
// R11 - The microcontroller disables the watchdog only outside normal operation.
// R12 - Only a high-to-low edge on the trigger input counts as a trigger.
// R13 - A state-change level held under 100 us is not valid; one held over 500 us takes effect.
// R14 - After a missed trigger the output stays low for a nominal 8 ms.
// R15 - All windows and filter times count ticks of one reference clock and restart on each state change.
package wddc_pkg;
  localparam int unsigned CLK_HZ           = 100_000_000;
  localparam int unsigned TRIG_WIN_MS      = 48;
  localparam int unsigned IGN_WIN_MS       = 16;
  localparam int unsigned OUT_LOW_MS       = 8;
  localparam int unsigned DIS_FILT_US      = 500;
  localparam int unsigned DIS_FILT_MIN_US  = 100;
  localparam int unsigned TRIG_WIN_CYC     = TRIG_WIN_MS * (CLK_HZ / 1000);
  localparam int unsigned IGN_WIN_CYC      = IGN_WIN_MS * (CLK_HZ / 1000);
  localparam int unsigned OUT_LOW_CYC      = OUT_LOW_MS * (CLK_HZ / 1000);
  localparam int unsigned DIS_FILT_CYC     = DIS_FILT_US * (CLK_HZ / 1000000);
  localparam int unsigned DIS_FILT_MIN_CYC = DIS_FILT_MIN_US * (CLK_HZ / 1000000);
  localparam int unsigned CNT_W            = 32;
  localparam logic        OUT_RST_VAL      = 1'b1;

  typedef enum logic [2:0] {
    WDDC_IGNORE,
    WDDC_TRIG_WAIT,
    WDDC_OUT_LOW,
    WDDC_DISABLED
  } wddc_state_t;
endpackage

// ### rtl/wddc_top.sv
`timescale 1ns/1ps
// Watchdog core with disable handling
module wddc_top
  import wddc_pkg::*;
#(
  parameter int unsigned TRIG_CYC = TRIG_WIN_CYC,
  parameter int unsigned IGN_CYC  = IGN_WIN_CYC,
  parameter int unsigned LOW_CYC  = OUT_LOW_CYC,
  parameter int unsigned FILT_CYC = DIS_FILT_CYC
) (
  input  wire logic ref_clk_i,
  input  wire logic srst_i,
  input  wire logic watchdog_trigger_input_i,
  input  wire logic disable_level_window_i,
  input  wire logic low_current_load_i,
  output logic      reset_watchdog_output_o,
  output logic      wd_disabled_o
);
  wddc_filt_if fif ();

  // State and window counting
  wddc_state_t      state_ff;
  wddc_state_t      nxt_state;
  logic [CNT_W-1:0] cnt_ff;
  logic             cnt_clr;
  logic             cnt_hit;

  // Low time carried into the disabled state
  logic [CNT_W-1:0] low_cnt_ff;
  logic [CNT_W-1:0] nxt_low_cnt;
  logic             low_done;
  logic             carry_low;

  // Trigger edge and output levels
  logic             trig_d_ff;
  logic             fall;
  logic             out_ff;
  logic             nxt_out;
  logic             dis_ff;

  // Terminal count of a window that counts up from zero
  function automatic logic win_hit(input logic [CNT_W-1:0] cnt,
                                   input int unsigned      len);
    logic [CNT_W-1:0] last;
    last    = CNT_W'(len - 1);
    win_hit = (cnt >= last);
  endfunction

  // Raw comparator flag into the dead-time filter
  assign fif.raw_dis = disable_level_window_i; // R2

  // Disable dead-time filter
  wddc_dis_filter #(
    .FILT_CYC (FILT_CYC)
  ) u_filt (
    .ref_clk_i (ref_clk_i),
    .srst_i    (srst_i),
    .fif       (fif)
  );

  // Trigger edge detect
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      trig_d_ff <= 1'b1;
    end else begin
      trig_d_ff <= watchdog_trigger_input_i;
    end
  end

  // Accepted trigger: high on one edge, low on the next
  assign fall = trig_d_ff & ~watchdog_trigger_input_i; // R12

  // Window terminal count per state
  always_comb begin
    cnt_hit = 1'b0;
    case (state_ff)
      WDDC_IGNORE: begin
        cnt_hit = win_hit(cnt_ff, IGN_CYC);
      end
      WDDC_TRIG_WAIT: begin
        cnt_hit = win_hit(cnt_ff, TRIG_CYC); // R1
      end
      WDDC_OUT_LOW: begin
        cnt_hit = win_hit(cnt_ff, LOW_CYC); // R14
      end
      default: begin
        cnt_hit = 1'b0;
      end
    endcase
  end

  // Full low time served, counting the part spent disabled
  assign low_done = win_hit(low_cnt_ff, LOW_CYC);

  // State transitions
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      WDDC_IGNORE: begin
        if (fif.dis_ok) begin
          nxt_state = WDDC_DISABLED; // R9
        end else if (cnt_hit) begin
          nxt_state = WDDC_TRIG_WAIT; // R4
        end
      end
      WDDC_TRIG_WAIT: begin
        if (fif.dis_ok) begin
          nxt_state = WDDC_DISABLED; // R6
        end else if (fall) begin
          // Accepted trigger restarts the window
          nxt_state = WDDC_TRIG_WAIT; // R12
        end else if (cnt_hit) begin
          nxt_state = WDDC_OUT_LOW; // R7
        end
      end
      WDDC_OUT_LOW: begin
        if (fif.dis_ok) begin
          nxt_state = WDDC_DISABLED; // R8
        end else if (cnt_hit) begin
          nxt_state = WDDC_IGNORE; // R9
        end
      end
      WDDC_DISABLED: begin
        if (!fif.dis_ok) begin
          nxt_state = WDDC_IGNORE; // R4 R5
        end
      end
      default: begin
        // Unused codes fall back to a fresh ignore window
        nxt_state = WDDC_IGNORE;
      end
    endcase
  end

  // Window restart on every state change or accepted trigger
  assign cnt_clr = (nxt_state != state_ff)
                   || (state_ff == WDDC_TRIG_WAIT && fall);

  // State register
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      state_ff <= WDDC_IGNORE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Window counter, one tick per reference clock
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      cnt_ff <= '0;
    end else if (cnt_clr) begin
      cnt_ff <= '0; // R15
    end else begin
      cnt_ff <= cnt_ff + 1'b1;
    end
  end

  // Low time served so far; parked at full outside a pulse
  always_comb begin
    nxt_low_cnt = low_cnt_ff;
    if (state_ff == WDDC_OUT_LOW) begin
      nxt_low_cnt = cnt_ff + 1'b1;
    end else if (state_ff == WDDC_DISABLED && !low_done) begin
      nxt_low_cnt = low_cnt_ff + 1'b1; // R8
    end else if (state_ff != WDDC_DISABLED) begin
      nxt_low_cnt = CNT_W'(LOW_CYC);
    end
  end

  // Low time register
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      low_cnt_ff <= '0;
    end else begin
      low_cnt_ff <= nxt_low_cnt;
    end
  end

  // Pulse still owed; once released it is never taken up again
  assign carry_low = (state_ff == WDDC_OUT_LOW)
                     || (state_ff == WDDC_DISABLED && !low_done && !out_ff);

  // Next output level
  always_comb begin
    nxt_out = 1'b1;
    case (nxt_state)
      WDDC_OUT_LOW: begin
        nxt_out = 1'b0; // R7
      end
      WDDC_DISABLED: begin
        if (carry_low) begin
          // Low pulse cut short by low-current-load end
          nxt_out = !low_current_load_i; // R8 R10
        end else begin
          nxt_out = 1'b1; // R6 R9
        end
      end
      default: begin
        nxt_out = 1'b1;
      end
    endcase
  end

  // Output register
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      out_ff <= OUT_RST_VAL;
    end else begin
      out_ff <= nxt_out;
    end
  end

  // Disabled status flag
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      dis_ff <= 1'b0;
    end else begin
      dis_ff <= (nxt_state == WDDC_DISABLED);
    end
  end

  // Outputs straight from their registers
  assign reset_watchdog_output_o = out_ff;
  assign wd_disabled_o           = dis_ff;
endmodule

// ### verif/tb_wddc_top.sv
`timescale 1ns/1ps
module tb_wddc_top;
  localparam int TC = 200, IC = 100, LC = 50, FC = 20;
  logic ref_clk = 1'b0, srst = 1'b1, lvl = 1'b0, lcl = 1'b0, en = 1'b0;
  logic [15:0] per = 16'h0064;
  logic trig, wo, wd;
  int errors = 0, tests_run = 0, n;
  always #5 ref_clk = ~ref_clk;
  wddc_mcu mcu_u (.ref_clk_i(ref_clk), .en_i(en), .per_i(per),
    .trig_o(trig));
  wddc_top #(.TRIG_CYC(TC), .IGN_CYC(IC), .LOW_CYC(LC), .FILT_CYC(FC))
  dut_u (.ref_clk_i(ref_clk), .srst_i(srst),
    .watchdog_trigger_input_i(trig), .disable_level_window_i(lvl),
    .low_current_load_i(lcl), .reset_watchdog_output_o(wo),
    .wd_disabled_o(wd));
  task automatic complete_run();
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic a, input logic b);
    tests_run++;
    if (a !== b) begin
      errors++;
      $display("MISMATCH %0t seen %b expected %b", $time, a, b);
    end
  endtask
  task automatic cy(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask
  // Cycles until wd or wo reads v, bounded
  task automatic wt(input bit s, input logic v, input int k);
    for (n = 0; n < k && (s ? wd : wo) !== v; n++) cy(1);
    if (n == k) begin
      errors++;
      complete_run();
    end
  endtask
  task automatic hi(input int k);
    repeat (k) begin
      cy(1);
      chk(wo, 1'b1);
    end
  endtask
  task automatic t_serve();
    @(posedge ref_clk) en <= 1'b1;
    repeat (3) begin
      @(posedge ref_clk) lvl <= 1'b1;
      cy(FC / 2);
      @(posedge ref_clk) lvl <= 1'b0;
      cy(FC / 2);
    end
    chk(wd, 1'b0);
    hi(4 * TC);
    @(posedge ref_clk) per <= 16'h00FA;
    wt(0, 1'b0, TC + 300);
    wt(0, 1'b1, LC + 5);
    chk(n >= LC - 1 && n <= LC + 1, 1'b1);
    $display("serve done");
  endtask
  task automatic t_dis_wait();
    @(posedge ref_clk) per <= 16'h0064;
    cy(TC + IC);
    @(posedge ref_clk) en <= 1'b0;
    @(posedge ref_clk) lvl <= 1'b1;
    wt(1, 1'b1, FC + 6);
    hi(2 * TC);
    @(posedge ref_clk) lvl <= 1'b0;
    wt(1, 1'b0, FC + 6);
    wt(0, 1'b0, IC + TC + 10);
    chk(n >= IC + TC - 3 && n <= IC + TC + 3, 1'b1);
    $display("disable in window done");
  endtask
  task automatic t_dis_low(input logic l);
    @(posedge ref_clk) lcl <= 1'b1;
    wt(0, 1'b0, IC + TC + 50);
    @(posedge ref_clk) lvl <= 1'b1;
    wt(1, 1'b1, FC + 6);
    chk(wo, 1'b0);
    // Low-current-load ends early when l is clear
    if (!l) @(posedge ref_clk) lcl <= 1'b0;
    wt(0, 1'b1, LC + 5);
    chk(l ? n >= LC - FC - 4 && n <= LC - FC : n <= 2, 1'b1);
    // Load state returning must not pull the output low again
    @(posedge ref_clk) lcl <= 1'b1;
    hi(TC);
    @(posedge ref_clk) lvl <= 1'b0;
    wt(1, 1'b0, FC + 6);
    @(posedge ref_clk) lcl <= 1'b0;
    $display("disable in low pulse done");
  endtask
  task automatic t_dis_ign();
    wt(0, 1'b0, IC + TC + 50);
    wt(0, 1'b1, LC + 5);
    @(posedge ref_clk) lvl <= 1'b1;
    wt(1, 1'b1, FC + 6);
    hi(TC);
    @(posedge ref_clk) lvl <= 1'b0;
    wt(1, 1'b0, FC + 6);
    $display("disable in ignore done");
  endtask
  initial begin
    cy(9);
    @(posedge ref_clk) srst <= 1'b0;
    cy(1);
    chk(wo, 1'b1);
    chk(wd, 1'b0);
    t_serve();
    t_dis_wait();
    t_dis_low(1'b1);
    t_dis_low(1'b0);
    t_dis_ign();
    complete_run();
  end
endmodule

// ### verif/wddc_checker.sv
`timescale 1ns/1ps
module wddc_checker #(
  parameter int unsigned TRIG_CYC = 200,
  parameter int unsigned LOW_CYC  = 50,
  parameter int unsigned FILT_CYC = 20
) (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic watchdog_trigger_input_i,
  input wire logic disable_level_window_i,
  input wire logic low_current_load_i,
  input wire logic reset_watchdog_output_o,
  input wire logic wd_disabled_o
);
  logic [31:0] lo_ff, qt_ff, hi_ff, rl_ff;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);
  // Run lengths: output low, trigger quiet, level high, level low
  always_ff @(posedge ref_clk_i) begin
    lo_ff <= (srst_i || reset_watchdog_output_o) ? 32'h0 : lo_ff + 32'h1;
    qt_ff <= (srst_i || $fell(watchdog_trigger_input_i)) ? 32'h0 :
             qt_ff + 32'h1;
    hi_ff <= (srst_i || !disable_level_window_i) ? 32'h0 : hi_ff + 32'h1;
    rl_ff <= (srst_i || disable_level_window_i) ? 32'h0 : rl_ff + 32'h1;
  end
  win_expiry_a: assert property (
    $fell(reset_watchdog_output_o) |-> qt_ff >= TRIG_CYC - 2)
    else $error("output low before window end");
  low_len_a: assert property (lo_ff <= LOW_CYC + 1)
    else $error("output low too long");
  dis_entry_a: assert property (
    $rose(wd_disabled_o) |-> hi_ff >= FILT_CYC - 1)
    else $error("disable taken too early");
  dis_take_a: assert property (
    hi_ff == FILT_CYC + 4 |-> wd_disabled_o) else $error("no disable");
  rel_take_a: assert property (
    rl_ff == FILT_CYC + 4 |-> !wd_disabled_o) else $error("no release");
  dis_high_a: assert property (
    wd_disabled_o && $past(wd_disabled_o) && $past(reset_watchdog_output_o)
    |-> reset_watchdog_output_o) else $error("low while disabled");
  lcl_cut_a: assert property (
    wd_disabled_o && !reset_watchdog_output_o && !low_current_load_i
    |-> ##[0:2] reset_watchdog_output_o) else $error("low kept");
  rst_val_a: assert property (
    $fell(srst_i) |-> reset_watchdog_output_o && !wd_disabled_o)
    else $error("bad reset value");
  reenable_a: assert property (
    $fell(wd_disabled_o) |-> reset_watchdog_output_o[*8])
    else $error("no ignore window");
  no_dis_low_a: assert property (
    $fell(reset_watchdog_output_o) |-> !wd_disabled_o)
    else $error("low pulse while disabled");
  cover property ($rose(wd_disabled_o));
  cover property ($fell(reset_watchdog_output_o));
  cover property (wd_disabled_o && !reset_watchdog_output_o);
  cover property (wd_disabled_o && !reset_watchdog_output_o &&
    !low_current_load_i);
endmodule
bind wddc_top wddc_checker #(.TRIG_CYC(TRIG_CYC), .LOW_CYC(LOW_CYC),
  .FILT_CYC(FILT_CYC)) chk_u (.ref_clk_i(ref_clk_i), .srst_i(srst_i),
  .watchdog_trigger_input_i(watchdog_trigger_input_i),
  .disable_level_window_i(disable_level_window_i),
  .low_current_load_i(low_current_load_i),
  .reset_watchdog_output_o(reset_watchdog_output_o),
  .wd_disabled_o(wd_disabled_o));

// ### verif/wddc_mcu.sv
`timescale 1ns/1ps
// Controller serving the trigger pin, one fall per period
module wddc_mcu (
  input  wire logic        ref_clk_i,
  input  wire logic        en_i,
  input  wire logic [15:0] per_i,
  output logic             trig_o
);
  logic [15:0] cnt_ff = 16'h0000;
  // Period counter
  always_ff @(posedge ref_clk_i) begin
    cnt_ff <= (!en_i || cnt_ff >= per_i) ? 16'h0000 : cnt_ff + 16'h0001;
  end
  // Idle high, short low near period end
  assign trig_o = !(en_i && cnt_ff >= per_i - 16'h0002);
endmodule
